//--- core/burst_skid_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module burst_skid_buffer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_r [0:1];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // a flush drops both entries so a restarted burst never sees stale words
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            case ({push, pop})
                2'b10: count_r <= count_r + 2'h1;
                2'b01: count_r <= count_r - 2'h1;
                default: count_r <= count_r;
            endcase
        end
    end

endmodule : burst_skid_buffer

`default_nettype wire

//--- core/flash_linear_burst_read.sv
// linear burst read engine with its burst configuration register
// Functional notes
// - bursts of 2, 4 or 8 words
// - order starts at start address, wraps
// - end flag low on final transfer
// - continued clocking repeats from burst start
// - end flag floats unless output enable low
// - flag one clock, last or second-last
// - data launched each rising edge, held one clock
// - reset ends burst, floats, restores defaults
// - chip select high ends burst, floats bus
// - strobe low at edge latches address, starts
// - new strobe discards old burst address
// - output enable high floats only, sequence continues
// - latency codes 0 to 7 give 2-9 clocks
// - reset leaves asynchronous mode, default config
// - chip select never alters configuration
// - config readable; writes ignored while busy
// - config on lower half, upper reads zero
// - config read latches bank, others array
// - read mode bit 15: 0 burst, 1 async
// - length codes 1-3 enable, others disable
// - config reads are single-cycle, held
`timescale 1ns/100ps
`default_nettype none
`include "flash_burst_map.svh"

module flash_linear_burst_read #(
    parameter int ADDR_W = 20,
    parameter int BANK_BIT = 19
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic address_valid_strobe_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic cfg_wr_en,
    input wire logic [`CFG_WIDTH-1:0] cfg_wr_data,
    input wire logic cfg_rd_cmd,
    input wire logic cfg_rd_exit,
    input wire logic algorithm_busy,
    output logic [ADDR_W-1:0] array_addr,
    output logic array_rd_en,
    input wire logic array_rd_valid,
    output logic array_rd_ready,
    input wire logic [31:0] array_rd_data,
    output logic [15:0] lower_data_lines,
    output logic [15:0] upper_data_lines,
    output logic data_lines_oe,
    output logic end_of_burst_flag_n,
    output logic end_of_burst_flag_oe,
    output logic [`CFG_WIDTH-1:0] burst_configuration,
    output logic burst_active
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [2:0] len_mask(input logic [2:0] code);
        case (code)
            `BL_CODE_2: len_mask = 3'h1;
            `BL_CODE_4: len_mask = 3'h3;
            `BL_CODE_8: len_mask = 3'h7;
            default: len_mask = 3'h0;
        endcase
    endfunction : len_mask

    // index bits above the length stay put, so a burst never leaves its aligned group
    function automatic logic [2:0] wrap_inc(input logic [2:0] idx, input logic [2:0] mask);
        wrap_inc = (idx & ~mask) | ((idx + 3'h1) & mask);
    endfunction : wrap_inc

    // ****************************************
    // configuration register
    // ****************************************
    logic [`CFG_WIDTH-1:0] cfg_r;
    logic cfg_rd_mode_r;
    logic cfg_bank_r;

    // only the reset pin restores defaults; chip select plays no part
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r <= `CFG_RESET;
        end else if (cfg_wr_en && !algorithm_busy) begin
            cfg_r <= cfg_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_rd_mode_r <= 1'b0;
            cfg_bank_r <= 1'b0;
        end else if (cfg_rd_cmd) begin
            cfg_rd_mode_r <= 1'b1;
            cfg_bank_r <= addr[BANK_BIT];
        end else if (cfg_rd_exit) begin
            cfg_rd_mode_r <= 1'b0;
        end
    end

    logic [2:0] mask;
    logic [3:0] lat_code;
    logic burst_enabled;
    logic end_timing;
    logic cfg_hit;

    assign mask = len_mask(cfg_r[`CFG_BL_HI:`CFG_BL_LO]);
    // codes above the table are clamped to the longest delay
    assign lat_code = (cfg_r[`CFG_LAT_HI:`CFG_LAT_LO] > `LAT_MAX_CODE) ? `LAT_MAX_CODE
                      : cfg_r[`CFG_LAT_HI:`CFG_LAT_LO];
    assign burst_enabled = !cfg_r[`CFG_READ_MODE_BIT] && (mask != 3'h0);
    assign end_timing = cfg_r[`CFG_END_TIMING_BIT];
    assign cfg_hit = cfg_rd_mode_r && (addr[BANK_BIT] == cfg_bank_r);

    // ****************************************
    // burst sequencer
    // ****************************************
    flash_burst_pkg::burst_state_type state_r;
    logic [3:0] lat_cnt_r;
    logic [2:0] beat_r;
    logic start;
    logic launch;
    logic abort;

    // strobe low at an edge starts a burst, even one already running
    assign start = !chip_select_n && !address_valid_strobe_n && burst_enabled
                   && !cfg_hit;
    assign abort = chip_select_n;
    assign launch = !abort && !start
                    && ((state_r == flash_burst_pkg::ST_WAIT && lat_cnt_r == 4'h0)
                        || state_r == flash_burst_pkg::ST_BURST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= flash_burst_pkg::ST_IDLE;
        end else if (abort) begin
            state_r <= flash_burst_pkg::ST_IDLE;
        end else if (start) begin
            state_r <= flash_burst_pkg::ST_WAIT;
        end else begin
            case (state_r)
                flash_burst_pkg::ST_IDLE: state_r <= flash_burst_pkg::ST_IDLE;
                flash_burst_pkg::ST_WAIT: begin
                    if (lat_cnt_r == 4'h0) begin
                        state_r <= flash_burst_pkg::ST_BURST;
                    end
                end
                flash_burst_pkg::ST_BURST: state_r <= flash_burst_pkg::ST_BURST;
                default: state_r <= flash_burst_pkg::ST_IDLE;
            endcase
        end
    end

    // first data edge comes latency clocks after the start edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lat_cnt_r <= 4'h0;
        end else if (start) begin
            lat_cnt_r <= lat_code + `LAT_BASE - 4'h1;
        end else if (state_r == flash_burst_pkg::ST_WAIT && lat_cnt_r != 4'h0) begin
            lat_cnt_r <= lat_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || start) begin
            beat_r <= 3'h0;
        end else if (launch) begin
            beat_r <= wrap_inc(beat_r, mask);
        end
    end

    // ****************************************
    // array fetch through the two-entry buffer
    // ****************************************
    logic [2:0] fetch_idx_r;
    logic [ADDR_W-4:0] group_r;
    logic fetch_en_r;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [31:0] buf_out_data;
    logic fetch_fire;

    assign fetch_fire = fetch_en_r && array_rd_valid && buf_in_ready;

    // the fetch runs ahead of the beats and stalls on a full buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_en_r <= 1'b0;
            fetch_idx_r <= 3'h0;
            group_r <= '0;
        end else if (abort) begin
            fetch_en_r <= 1'b0;
        end else if (start) begin
            fetch_en_r <= 1'b1;
            fetch_idx_r <= addr[2:0];
            group_r <= addr[ADDR_W-1:3];
        end else if (fetch_fire) begin
            fetch_idx_r <= wrap_inc(fetch_idx_r, mask);
        end
    end

    // moves together with the fetch index, so each fetched word answers its own address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            array_addr <= '0;
        end else if (start) begin
            array_addr <= addr;
        end else if (fetch_fire && !abort) begin
            array_addr <= {group_r, wrap_inc(fetch_idx_r, mask)};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            array_rd_en <= 1'b0;
            array_rd_ready <= 1'b0;
        end else begin
            // first fetch leaves at the start edge so a two-clock latency finds its word
            array_rd_en <= start || (fetch_en_r && !abort);
            array_rd_ready <= fetch_en_r && buf_in_ready && !abort && !start;
        end
    end

    burst_skid_buffer #(
        .WIDTH(32)
    ) u_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .flush(start || abort),
        .in_valid(fetch_en_r && array_rd_valid),
        .in_ready(buf_in_ready),
        .in_data(array_rd_data),
        .out_valid(buf_out_valid),
        .out_ready(launch),
        .out_data(buf_out_data)
    );

    // ****************************************
    // pin drivers
    // ****************************************
    logic [31:0] word_nxt;
    logic end_hit;

    always_comb begin
        word_nxt = {upper_data_lines, lower_data_lines};
        if (cfg_hit) begin
            word_nxt = {16'h0000, cfg_r};
        end else if (launch && buf_out_valid) begin
            word_nxt = buf_out_data;
        end
    end

    // second-last beat is one below the last beat index, beat 0 for two-word bursts
    assign end_hit = launch
                     && (beat_r == (end_timing ? ((mask - 3'h1) & mask) : mask));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lower_data_lines <= 16'h0000;
            upper_data_lines <= 16'h0000;
        end else begin
            lower_data_lines <= word_nxt[15:0];
            upper_data_lines <= word_nxt[31:16];
        end
    end

    // output enable gates the pins only; the sequencer ignores it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_lines_oe <= 1'b0;
        end else begin
            data_lines_oe <= !output_enable_n && !chip_select_n
                             && (cfg_hit || launch);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            end_of_burst_flag_n <= 1'b1;
            end_of_burst_flag_oe <= 1'b0;
        end else begin
            end_of_burst_flag_n <= !end_hit;
            end_of_burst_flag_oe <= !output_enable_n;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            burst_configuration <= `CFG_RESET;
            burst_active <= 1'b0;
        end else begin
            burst_configuration <= cfg_r;
            burst_active <= launch;
        end
    end

endmodule : flash_linear_burst_read

`default_nettype wire

//--- dv/flash_array_model.sv
// flash array model answering word fetches
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic [19:0] array_addr,
    input wire logic array_rd_en,
    output logic array_rd_valid,
    output logic [31:0] array_rd_data
);
    logic stall_r;
    // stall taken at the edge so valid never moves mid-cycle
    always_ff @(posedge clk) begin
        stall_r <= stall;
    end
    assign array_rd_valid = array_rd_en && !stall_r;
    // inverted word when idle, a stale sample cannot match
    assign array_rd_data = array_rd_valid ? {12'hc30, array_addr} : ~{12'hc30, array_addr};
endmodule : flash_array_model
`default_nettype wire

//--- dv/flash_linear_burst_read_sva.sv
// port checks of the burst read engine
`timescale 1ns/100ps
`default_nettype none
module flash_burst_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic address_valid_strobe_n,
    input wire logic output_enable_n,
    input wire logic cfg_wr_en,
    input wire logic [15:0] cfg_wr_data,
    input wire logic algorithm_busy,
    input wire logic data_lines_oe,
    input wire logic end_of_burst_flag_n,
    input wire logic end_of_burst_flag_oe,
    input wire logic [15:0] burst_configuration,
    input wire logic burst_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic start;
    assign start = !chip_select_n && !address_valid_strobe_n && !burst_configuration[15]
        && burst_configuration[2:0] inside {3'h1, 3'h2, 3'h3};
    a_reset_default: assert property (
        disable iff (1'b0) !rst_n |=> burst_configuration == 16'h9cc4 && !data_lines_oe)
        else $error("reset left outputs active");
    a_cs_float: assert property (chip_select_n |=> !data_lines_oe && !burst_active)
        else $error("bus driven while deselected");
    a_oe_float: assert property (
        output_enable_n |=> !data_lines_oe && !end_of_burst_flag_oe)
        else $error("driven while output enable high");
    a_start_wait: assert property (start |=> !burst_active)
        else $error("beat right after start");
    a_busy_hold: assert property (
        cfg_wr_en && algorithm_busy |=> $stable(burst_configuration) [*2])
        else $error("config written while busy");
    a_cfg_load: assert property (
        cfg_wr_en && !algorithm_busy |-> ##2 burst_configuration == $past(cfg_wr_data, 2))
        else $error("config write lost");
    a_cs_keeps_cfg: assert property (
        $rose(chip_select_n) |=> $stable(burst_configuration))
        else $error("config changed by deselect");
    a_flag_one: assert property (!end_of_burst_flag_n |=> end_of_burst_flag_n)
        else $error("end flag longer than one clock");
    a_flag_beat: assert property (
        !end_of_burst_flag_n && end_of_burst_flag_oe |-> burst_active)
        else $error("end flag outside a beat");
endmodule : flash_burst_checker
bind flash_linear_burst_read flash_burst_checker u_checker (.clk, .rst_n, .chip_select_n,
    .address_valid_strobe_n, .output_enable_n, .cfg_wr_en, .cfg_wr_data, .algorithm_busy,
    .data_lines_oe, .end_of_burst_flag_n, .end_of_burst_flag_oe, .burst_configuration,
    .burst_active);
`default_nettype wire

//--- dv/test_flash_linear_burst_read.sv
// self-checking bench of the burst read engine
`timescale 1ns/100ps
`default_nettype none
module test_flash_linear_burst_read;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n = 1'b1;
    logic avs_n = 1'b1;
    logic oe_n = 1'b1;
    logic [19:0] addr = 20'h00000;
    logic wr_en = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic rd_cmd = 1'b0;
    logic rd_exit = 1'b0;
    logic busy = 1'b0;
    logic [19:0] a_addr;
    logic a_en, a_valid, a_ready, d_oe, flag_n, flag_oe, active;
    logic [31:0] a_data;
    logic [15:0] lo, hi, cfg;
    int mismatches = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    flash_linear_burst_read DUT (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .address_valid_strobe_n(avs_n), .output_enable_n(oe_n), .addr(addr),
        .cfg_wr_en(wr_en), .cfg_wr_data(wr_data), .cfg_rd_cmd(rd_cmd), .cfg_rd_exit(rd_exit),
        .algorithm_busy(busy), .array_addr(a_addr), .array_rd_en(a_en),
        .array_rd_valid(a_valid), .array_rd_ready(a_ready), .array_rd_data(a_data),
        .lower_data_lines(lo), .upper_data_lines(hi), .data_lines_oe(d_oe),
        .end_of_burst_flag_n(flag_n), .end_of_burst_flag_oe(flag_oe),
        .burst_configuration(cfg), .burst_active(active));
    flash_array_model u_array (.clk(clk), .stall(1'b0), .array_addr(a_addr),
        .array_rd_en(a_en), .array_rd_valid(a_valid), .array_rd_data(a_data));
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic cfg_write(logic [15:0] v);
        wr_data = v;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        tick(3);
    endtask : cfg_write
    // host keeps hold 0, linear order 1, rising edge 1, bit 14 at 0
    function automatic logic [15:0] cfg_of(logic [2:0] bl, logic wt, logic [3:0] lat);
        return {2'b00, lat, 1'b0, wt, 2'b11, 3'b000, bl};
    endfunction : cfg_of
    task automatic stop();
        cs_n = 1'b1;
        avs_n = 1'b1;
        oe_n = 1'b1;
        tick(2);
    endtask : stop
    task automatic launch(logic [19:0] a, int lat);
        addr = a;
        cs_n = 1'b0;
        oe_n = 1'b0;
        avs_n = 1'b0;
        tick(1);
        avs_n = 1'b1;
        tick(lat + 1);
        check("early beat", active, 0);
        tick(1);
    endtask : launch
    task automatic beats(logic [19:0] a, int len, logic wt, int k0, int n);
        logic [19:0] w;
        for (int k = k0; k < k0 + n; k++) begin
            w = 20'((a & ~(len - 1)) | ((a + k) & (len - 1)));
            check("word", {hi, lo}, {12'hc30, w});
            check("end flag", flag_n, (k % len) != (len - 1 - wt));
            check("drive", {d_oe, flag_oe, a_en}, 3'b111);
            tick(1);
        end
    endtask : beats
    task automatic t_burst(logic [2:0] bl, logic [19:0] a, logic wt, int lat);
        cfg_write(cfg_of(bl, wt, 4'(lat)));
        launch(a, lat);
        beats(a, 1 << bl, wt, 0, 2 << bl);
        stop();
    endtask : t_burst
    task automatic probe();
        addr = 20'h00002;
        cs_n = 1'b0;
        oe_n = 1'b0;
        avs_n = 1'b0;
        tick(1);
        avs_n = 1'b1;
        tick(10);
        check("async beat", {active, d_oe}, 2'b00);
        stop();
    endtask : probe
    task automatic t_async();
        probe();
        for (int c = 3; c < 7; c++) begin
            cfg_write(cfg_of((c == 3) ? 3'h0 : 3'(c), 1'b0, 4'h1));
            probe();
        end
        cfg_write(cfg_of(3'h3, 1'b0, 4'h1) | 16'h8000);
        probe();
    endtask : t_async
    task automatic t_oe_cs();
        cfg_write(cfg_of(3'h3, 1'b0, 4'h1));
        launch(20'h00010, 1);
        beats(20'h00010, 8, 1'b0, 0, 2);
        oe_n = 1'b1;
        tick(1);
        check("floated", {d_oe, flag_oe, active}, 3'b001);
        oe_n = 1'b0;
        tick(1);
        beats(20'h00010, 8, 1'b0, 4, 4);
        launch(20'h00022, 1);
        beats(20'h00022, 8, 1'b0, 0, 3);
        cs_n = 1'b1;
        tick(1);
        check("abort", {d_oe, active, a_en, a_ready}, 4'b0000);
        tick(4);
        check("kept", cfg, cfg_of(3'h3, 1'b0, 4'h1));
        stop();
        busy = 1'b1;
        cfg_write(16'h0000);
        busy = 1'b0;
        check("busy write", cfg, cfg_of(3'h3, 1'b0, 4'h1));
    endtask : t_oe_cs
    task automatic t_cfg_read();
        cfg_write(cfg_of(3'h2, 1'b1, 4'h2));
        addr = 20'h80000;
        cs_n = 1'b0;
        oe_n = 1'b0;
        rd_cmd = 1'b1;
        tick(1);
        rd_cmd = 1'b0;
        avs_n = 1'b0;
        tick(1);
        avs_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            tick(3);
            check("cfg read", {active, d_oe, hi, lo}, {2'b01, 16'h0000, cfg_of(3'h2, 1'b1, 4'h2)});
        end
        launch(20'h00005, 2);
        beats(20'h00005, 4, 1'b1, 0, 4);
        rd_exit = 1'b1;
        tick(1);
        rd_exit = 1'b0;
        launch(20'h00003, 2);
        beats(20'h00003, 4, 1'b1, 0, 2);
        rst_n = 1'b0;
        tick(1);
        check("reset in burst", {d_oe, cfg}, {1'b0, 16'h9cc4});
        rst_n = 1'b1;
        stop();
    endtask : t_cfg_read
    initial begin
        #50us;
        mismatches++;
        wrap_up();
    end
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(1);
        check("reset state", {d_oe, flag_oe, flag_n, cfg}, {3'b001, 16'h9cc4});
        t_async();
        t_burst(3'h1, 20'h40001, 1'b0, 7);
        t_burst(3'h1, 20'h00000, 1'b1, 2);
        t_burst(3'h2, 20'h00006, 1'b1, 0);
        t_burst(3'h3, 20'h12343, 1'b0, 3);
        t_oe_cs();
        t_cfg_read();
        wrap_up();
    end
endmodule : test_flash_linear_burst_read
`default_nettype wire

//--- include/flash_burst_map.svh
// register layout, reset value and timing counts of the burst read engine
`ifndef FLASH_BURST_MAP_SVH
`define FLASH_BURST_MAP_SVH

// ****************************************
// burst configuration register fields
// ****************************************
`define CFG_WIDTH 16
`define CFG_RESET 16'h9cc4
`define CFG_READ_MODE_BIT 15
`define CFG_RSVD_BIT 14
`define CFG_LAT_HI 13
`define CFG_LAT_LO 10
`define CFG_HOLD_BIT 9
`define CFG_END_TIMING_BIT 8
`define CFG_ORDER_BIT 7
`define CFG_EDGE_BIT 6
`define CFG_BL_HI 2
`define CFG_BL_LO 0

// ****************************************
// burst length codes and latency base
// ****************************************
`define BL_CODE_2 3'h1
`define BL_CODE_4 3'h2
`define BL_CODE_8 3'h3
`define LAT_BASE 4'h2
`define LAT_MAX_CODE 4'h7

`endif

//--- include/flash_burst_pkg.sv
// types shared by the burst read engine
package flash_burst_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_BURST = 3'b100
    } burst_state_type;

endpackage : flash_burst_pkg
